// ==== hdl/arp_ctrl.sv ====
// Reference DAC programming, power-down modes and software reset of the parallel port
`timescale 1ns/1ps
module arp_ctrl
    import arp_pkg::*;
(
    input wire logic sys_clk,                   // 10 MHz conversion clock
    input wire logic rstn,                      // Synchronous reset, active low
    input wire logic writeStrobe_n,             // Write strobe, active low
    input wire logic readStrobe_n,              // Read strobe, active low
    input wire logic conversion_start_n,        // Conversion start, active low
    input wire logic [11:0] parallelDataIn,     // Data bus from host
    output logic [11:0] parallelDataOut,        // Data bus to host
    output logic parallelDataOe,                // High while driving the bus
    output logic [1:0] channelPick,             // Selected input channel
    output logic analogEnable,                  // Analog blocks powered
    output logic biasEnable,                    // Comparator and buffer bias on
    output logic convBusy,                      // Conversion running
    output logic deviceReady,                   // Interface accepts accesses
    output logic [9:0] referenceLevel           // Reference DAC setting
);
    arp_timer_if tif ();
    arp_timer u_timer (.sysClk(sys_clk), .rstn(rstn), .tif(tif));

    logic wrPrev_r, rdPrev_r, csPrev_r;
    logic [11:0] cfg_r, cfg_nxt;
    logic [9:0] dac_r, dac_nxt;
    arp_wmode_t wmode_r, wmode_nxt;
    logic rdDac_r, rdDac_nxt;
    logic [11:0] dout_r, dout_nxt;
    arp_pwr_t pwr_r, pwr_nxt;
    logic deepMode_r, deepMode_nxt;
    logic [4:0] conv_r, conv_nxt;
    logic convOn_r, convOn_nxt;
    logic [1:0] swRst_r, swRst_nxt;
    logic wrRise, rdFall, csFall, cfgWr;
    logic [2:0] act;

    // Field decode used on every configuration write
    function automatic logic isCtl(input logic [11:0] w, input logic [2:0] code);
        return w[REG_SEL_LSB +: 2] == REG_SEL_CFG && w[ACT_LSB +: 3] == code;
    endfunction

    assign wrRise = writeStrobe_n && !wrPrev_r;
    assign rdFall = !readStrobe_n && rdPrev_r;
    assign csFall = !conversion_start_n && csPrev_r;
    assign act = parallelDataIn[ACT_LSB +: 3];
    assign cfgWr = wrRise && wmode_r == WM_CFG && swRst_r == '0;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wrPrev_r <= 1'b1;
            rdPrev_r <= 1'b1;
            csPrev_r <= 1'b1;
        end else begin
            wrPrev_r <= writeStrobe_n;
            rdPrev_r <= readStrobe_n;
            csPrev_r <= conversion_start_n;
        end
    end

    // Register write path; the strobe's rising edge commits everything
    always_comb begin
        cfg_nxt = cfg_r;
        dac_nxt = dac_r;
        wmode_nxt = wmode_r;
        rdDac_nxt = rdDac_r;
        dout_nxt = dout_r;
        swRst_nxt = swRst_r == '0 ? swRst_r : swRst_r - 2'h1;
        // Read first, so a read command committed in the same cycle survives
        if (rdFall) begin
            dout_nxt = rdDac_r ? {2'h0, dac_r} : 12'h000;
            rdDac_nxt = 1'b0;
        end
        if (wrRise && wmode_r == WM_DAC) begin
            dac_nxt = parallelDataIn[9:0];
            wmode_nxt = WM_CFG;
        end else if (cfgWr) begin
            if (isCtl(parallelDataIn, ACT_SW_RESET)) begin
                swRst_nxt = 2'(SW_RESET_CYC);
                cfg_nxt = CFG_RESET;
                dac_nxt = DAC_RESET;
                rdDac_nxt = 1'b0;
            end else begin
                cfg_nxt = parallelDataIn;
                wmode_nxt = isCtl(parallelDataIn, ACT_DAC_WR) ? WM_DAC : WM_CFG;
                rdDac_nxt = isCtl(parallelDataIn, ACT_DAC_RD);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfg_r <= CFG_RESET;
            dac_r <= DAC_RESET;
            wmode_r <= WM_CFG;
            rdDac_r <= 1'b0;
            dout_r <= 12'h000;
            swRst_r <= 2'h0;
        end else begin
            cfg_r <= cfg_nxt;
            dac_r <= dac_nxt;
            wmode_r <= wmode_nxt;
            rdDac_r <= rdDac_nxt;
            dout_r <= dout_nxt;
            swRst_r <= swRst_nxt;
        end
    end

    // Power state; only reads cfg, never writes it
    always_comb begin
        logic wantDeep, wantNap, autoOn;
        wantDeep = cfg_r[DEEP_BIT];
        wantNap = cfg_r[NAP_BIT];
        autoOn = cfg_r[AUTO_BIT];
        pwr_nxt = pwr_r;
        deepMode_nxt = deepMode_r;
        tif.load = 1'b0;
        tif.count = '0;
        // Timer runs down to zero inclusive, so each load is one less than the cycles wanted
        case (pwr_r)
            PW_RUN: begin
                if (cfgWr && (parallelDataIn[DEEP_BIT] || parallelDataIn[NAP_BIT])) begin
                    pwr_nxt = PW_ENTER;
                    deepMode_nxt = parallelDataIn[DEEP_BIT];
                    tif.load = 1'b1;
                    tif.count = parallelDataIn[DEEP_BIT] ? CNT_W'(DEEP_ENTER_CYC - 1) : CNT_W'(NAP_ENTER_CYC - 1);
                end else if (autoOn && convOn_r && conv_r == 5'h1) begin
                    pwr_nxt = PW_ENTER;
                    deepMode_nxt = 1'b0;
                    tif.load = 1'b1;
                    tif.count = CNT_W'(NAP_ENTER_CYC - 1);
                end
            end
            PW_ENTER: begin
                if (tif.done) begin
                    pwr_nxt = PW_DOWN;
                end
            end
            PW_DOWN: begin
                if (deepMode_r ? !wantDeep : (!wantNap && !(autoOn && !csFall))) begin
                    pwr_nxt = PW_WAKE;
                    tif.load = 1'b1;
                    tif.count = deepMode_r ? CNT_W'(DEEP_WAKE_CYC - 1) : CNT_W'(NAP_WAKE_CYC - 1);
                end
            end
            PW_WAKE: begin
                if (tif.done) begin
                    pwr_nxt = PW_RUN;
                end
            end
            default: pwr_nxt = PW_RUN;
        endcase
        if (swRst_r != '0) begin
            pwr_nxt = PW_RUN;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pwr_r <= PW_RUN;
            deepMode_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            deepMode_r <= deepMode_nxt;
        end
    end

    // Conversion timer: counts the 16-clock body; auto-nap wake adds 6
    always_comb begin
        conv_nxt = conv_r;
        convOn_nxt = convOn_r;
        if (convOn_r) begin
            conv_nxt = conv_r - 5'h1;
            convOn_nxt = conv_r != 5'h1;
        end
        if (pwr_r == PW_WAKE && !deepMode_r && cfg_r[AUTO_BIT] && tif.done) begin
            convOn_nxt = 1'b1;
            conv_nxt = 5'(CONV_BODY_CYC);
        end else if (csFall && pwr_r == PW_RUN && !convOn_r) begin
            convOn_nxt = 1'b1;
            conv_nxt = 5'(CONV_BODY_CYC);
        end
        if (pwr_r != PW_RUN && pwr_nxt == PW_ENTER || swRst_r != '0
            || cfgWr && (parallelDataIn[DEEP_BIT] || parallelDataIn[NAP_BIT])) begin
            convOn_nxt = 1'b0;
            conv_nxt = 5'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            conv_r <= 5'h0;
            convOn_r <= 1'b0;
        end else begin
            conv_r <= conv_nxt;
            convOn_r <= convOn_nxt;
        end
    end

    // Outputs
    assign parallelDataOut = dout_r;
    assign parallelDataOe = !readStrobe_n;
    assign channelPick = cfg_r[CHAN_LSB +: 2];
    assign referenceLevel = dac_r;
    assign analogEnable = !(deepMode_r && pwr_r == PW_DOWN);
    assign biasEnable = pwr_r != PW_DOWN;
    assign convBusy = convOn_r;
    assign deviceReady = swRst_r == '0;

    // Assertions
    a_dac_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
        wrRise && wmode_r == WM_DAC |=> dac_r == $past(parallelDataIn[9:0]) && wmode_r == WM_CFG)
        else $error("DAC data not captured");
    a_dac_upper_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        rdFall && rdDac_r |=> parallelDataOut[11:10] == 2'h0)
        else $error("DAC readback upper bits not zero");
    a_dac_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        rdFall && rdDac_r |=> parallelDataOut[9:0] == $past(dac_r))
        else $error("DAC readback wrong");
    a_nap_enter: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfgWr && parallelDataIn[NAP_BIT] && !parallelDataIn[DEEP_BIT] && pwr_r == PW_RUN
        |=> ##[1:3] !biasEnable)
        else $error("Nap not entered in time");
    a_abort_conv: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfgWr && (parallelDataIn[DEEP_BIT] || parallelDataIn[NAP_BIT]) |=> !convBusy)
        else $error("Conversion not aborted");
    a_cfg_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wrRise && swRst_r == '0 |=> cfg_r == $past(cfg_r))
        else $error("Config changed without write");
    a_sw_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfgWr && isCtl(parallelDataIn, ACT_SW_RESET) |=> !deviceReady && dac_r == DAC_RESET ##1 deviceReady)
        else $error("Software reset wrong");
    a_deep_wake: assert property (@(posedge sys_clk) disable iff (!rstn)
        pwr_r == PW_DOWN && deepMode_r && !cfg_r[DEEP_BIT]
        |=> pwr_r == PW_WAKE && analogEnable ##9 pwr_r == PW_WAKE ##1 pwr_r == PW_RUN)
        else $error("Deep wake time wrong");
    a_next_is_data: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfgWr && isCtl(parallelDataIn, ACT_DAC_WR) |=> wmode_r == WM_DAC)
        else $error("DAC write not armed");
    c_dac_write: cover property (@(posedge sys_clk) wrRise && wmode_r == WM_DAC);
    c_deep_down: cover property (@(posedge sys_clk) !analogEnable);
    c_auto_conv: cover property (@(posedge sys_clk) pwr_r == PW_WAKE && cfg_r[AUTO_BIT] ##1 convBusy);
    c_sw_reset: cover property (@(posedge sys_clk) !deviceReady);
endmodule

// ==== hdl/arp_pkg.sv ====
// Package of constants and types for the reference and power-down control block
package arp_pkg;
    // Control word field positions
    localparam int REG_SEL_LSB = 10;        // Register-select field [11:10]
    localparam int ACT_LSB = 7;             // Action-code field [9:7]
    localparam int DEEP_BIT = 6;            // Deep power-down enable
    localparam int NAP_BIT = 5;             // Nap enable
    localparam int AUTO_BIT = 4;            // Auto-nap enable
    localparam int CHAN_LSB = 2;            // Channel-pick field [3:2]
    localparam logic [1:0] REG_SEL_CFG = 2'h1;
    localparam logic [2:0] ACT_DAC_WR = 3'h1;
    localparam logic [2:0] ACT_DAC_RD = 3'h3;
    localparam logic [2:0] ACT_SW_RESET = 3'h5;
    // Values after reset
    localparam logic [9:0] DAC_RESET = 10'h3FF;
    localparam logic [11:0] CFG_RESET = 12'h000;
    // Timing, figures as printed; ns figures turned into cycle counts from the clock, nap wake and conversion given in cycles
    localparam int CLK_HZ = 10_000_000;
    localparam int DEEP_ENTER_NS = 2000;
    localparam int DEEP_WAKE_NS = 1000;
    localparam int NAP_ENTER_NS = 200;
    localparam int SW_RESET_NS = 20;
    localparam int NAP_WAKE_CYC = 6;
    localparam int CONV_CYCLES = 22;
    localparam int CONV_BODY_CYC = CONV_CYCLES - NAP_WAKE_CYC;
    localparam longint NS_PER_S = 1_000_000_000;
    // Longest times round down, least times round up, none below one cycle
    localparam int DEEP_ENTER_CYC = (DEEP_ENTER_NS * CLK_HZ / NS_PER_S) < 1 ? 1
        : int'(DEEP_ENTER_NS * CLK_HZ / NS_PER_S);
    localparam int NAP_ENTER_CYC = (NAP_ENTER_NS * CLK_HZ / NS_PER_S) < 1 ? 1
        : int'(NAP_ENTER_NS * CLK_HZ / NS_PER_S);
    localparam int DEEP_WAKE_CYC = int'((DEEP_WAKE_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int SW_RESET_CYC = int'((SW_RESET_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int CNT_W = 6;
    // Power states
    typedef enum logic [2:0] {PW_RUN, PW_ENTER, PW_DOWN, PW_WAKE} arp_pwr_t;
    // Write-path interpretation
    typedef enum logic [1:0] {WM_CFG, WM_DAC} arp_wmode_t;
endpackage

// ==== hdl/arp_timer.sv ====
// Down counter that times power-state transitions
`timescale 1ns/1ps
module arp_timer
    import arp_pkg::*;
(
    input wire logic sysClk,    // System clock
    input wire logic rstn,      // Synchronous reset, active low
    arp_timer_if.tmr tif        // Load and done
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // Load wins, else count toward zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (tif.load) begin
            cnt_nxt = tif.count;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge sysClk) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Done looks at the count only, so control can read it beside load with no loop
    assign tif.done = cnt_r == '0;
endmodule

// ==== hdl/arp_timer_if.sv ====
// Interface between control and the power timing counter
`timescale 1ns/1ps
interface arp_timer_if;
    logic load;
    logic [arp_pkg::CNT_W-1:0] count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// ==== testbench/arp_ctrl_test.sv ====
// Self-checking bench for the reference DAC and power-down control block
`timescale 1ns/1ps
module arp_ctrl_test;
    import arp_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic writeStrobe_n, readStrobe_n, conversion_start_n, busyQ;
    logic [11:0] parallelDataIn, parallelDataOut, q;
    logic parallelDataOe, analogEnable, biasEnable, convBusy, deviceReady;
    logic [1:0] channelPick;
    logic [9:0] referenceLevel;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int notReady = 0;
    int dnAt = 0;
    int startAt, plainLen, autoLen, n;
    always #50 sys_clk = ~sys_clk;
    arp_ctrl u_dut (.sys_clk, .rstn, .writeStrobe_n, .readStrobe_n, .conversion_start_n, .parallelDataIn,
        .parallelDataOut, .parallelDataOe, .channelPick, .analogEnable, .biasEnable, .convBusy,
        .deviceReady, .referenceLevel);
    arp_host_model u_host (.sys_clk, .parallelDataOut, .writeStrobe_n, .readStrobe_n,
        .conversion_start_n, .parallelDataIn);
    // Cycle count, not-ready count and busy end time; ceiling cuts a hang short
    always @(posedge sys_clk) begin
        cycles++;
        busyQ <= convBusy;
        if (deviceReady === 1'b0) notReady++;
        chk_bit(parallelDataOe, !readStrobe_n);
        if (convBusy === 1'b0 && busyQ === 1'b1) dnAt = cycles;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    function automatic logic [11:0] cw(input logic [2:0] act, input logic [6:0] low);
        return {REG_SEL_CFG, act, low};
    endfunction
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // Timed conversion; length measured from the start call to the busy fall
    task automatic conv(output int len);
        startAt = cycles;
        u_host.start();
        repeat (30) @(negedge sys_clk);
        len = dnAt - startAt;
    endtask
    task automatic stop_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        chk({2'h0, referenceLevel}, {2'h0, DAC_RESET});
        u_host.rd(q);
        chk(q, 12'h000);
        u_host.wr(cw(ACT_DAC_RD, 7'h00));
        u_host.rd(q);
        chk(q, 12'h3FF);
        // Data word whose upper half looks like a reset action code
        u_host.wr(cw(ACT_DAC_WR, 7'h00));
        chk({2'h0, referenceLevel}, 12'h3FF);
        n = notReady;
        u_host.wr(12'h2D0);
        chk({2'h0, referenceLevel}, 12'h2D0);
        chk_bit(notReady == n, 1'b1);
        u_host.wr(cw(ACT_DAC_RD, 7'h00));
        u_host.rd(q);
        chk(q, 12'h2D0);
        // Deep power-down with channel 3 picked
        u_host.wr(cw(3'h0, 7'h4C));
        repeat (DEEP_ENTER_CYC) @(negedge sys_clk);
        chk_bit(analogEnable, 1'b0);
        chk_bit(biasEnable, 1'b0);
        chk({10'h0, channelPick}, 12'h003);
        u_host.wr(cw(3'h0, 7'h0C));
        repeat (DEEP_WAKE_CYC) @(negedge sys_clk);
        chk_bit(analogEnable, 1'b1);
        chk({10'h0, channelPick}, 12'h003);
        // Nap entered in mid-conversion aborts it
        u_host.start();
        chk_bit(convBusy, 1'b1);
        u_host.wr(cw(3'h0, 7'h20));
        repeat (NAP_ENTER_CYC) @(negedge sys_clk);
        chk_bit(convBusy, 1'b0);
        chk_bit(biasEnable, 1'b0);
        chk_bit(analogEnable, 1'b1);
        u_host.wr(cw(3'h0, 7'h00));
        repeat (NAP_WAKE_CYC + 2) @(negedge sys_clk);
        chk_bit(biasEnable, 1'b1);
        // Auto-nap adds the wake time to each conversion started from nap
        conv(plainLen);
        chk_bit(plainLen <= CONV_BODY_CYC + 3, 1'b1);
        u_host.wr(cw(3'h0, 7'h10));
        conv(autoLen);
        chk_bit(biasEnable, 1'b0);
        conv(autoLen);
        chk_bit(biasEnable, 1'b0);
        chk_bit(autoLen - plainLen >= NAP_WAKE_CYC && autoLen - plainLen <= NAP_WAKE_CYC + 2, 1'b1);
        u_host.wr(cw(3'h0, 7'h00));
        repeat (NAP_WAKE_CYC + 2) @(negedge sys_clk);
        chk_bit(biasEnable, 1'b1);
        // Software reset returns the DAC to 3FF and clears the channel, port comes back
        u_host.wr(cw(ACT_DAC_WR, 7'h00));
        u_host.wr(12'h155);
        u_host.wr(cw(3'h0, 7'h08));
        chk({10'h0, channelPick}, 12'h002);
        n = notReady;
        u_host.wr(cw(ACT_SW_RESET, 7'h00));
        repeat (3) @(negedge sys_clk);
        chk_bit(notReady > n, 1'b1);
        chk({2'h0, referenceLevel}, 12'h3FF);
        chk({10'h0, channelPick}, 12'h000);
        u_host.wr(cw(ACT_DAC_RD, 7'h00));
        u_host.rd(q);
        chk(q, 12'h3FF);
        stop_test();
    end
endmodule

// ==== testbench/arp_host_model.sv ====
// Host-side model that drives the parallel port strobes, data and start pulse
`timescale 1ns/1ps
module arp_host_model (
    input wire logic sys_clk,                // Conversion clock
    input wire logic [11:0] parallelDataOut, // Read data from the device
    output logic writeStrobe_n,              // Write strobe, active low
    output logic readStrobe_n,               // Read strobe, active low
    output logic conversion_start_n,         // Start pulse, active low
    output logic [11:0] parallelDataIn       // Write data to the device
);
    // Idle levels from time zero, strobes high through reset release
    initial begin
        writeStrobe_n = 1'b1;
        readStrobe_n = 1'b1;
        conversion_start_n = 1'b1;
        parallelDataIn = 12'h000;
    end
    // One write; data held past the commit, then inverted so stale data is never seen
    task automatic wr(input logic [11:0] d);
        @(negedge sys_clk);
        parallelDataIn = d;
        writeStrobe_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        writeStrobe_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        parallelDataIn = ~d;
        @(negedge sys_clk);
    endtask
    // One read, data taken while the strobe is still low
    task automatic rd(output logic [11:0] q);
        @(negedge sys_clk);
        readStrobe_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        q = parallelDataOut;
        readStrobe_n = 1'b1;
        @(negedge sys_clk);
    endtask
    // Start pulse launched off the falling edge, fixed phase to the clock
    task automatic start();
        @(negedge sys_clk);
        conversion_start_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        conversion_start_n = 1'b1;
    endtask
endmodule
